// ===== hdl/bcr_consts.svh
// register offsets, field positions, reset values and limit codes for the converter config bank
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// ****************************************************************
// register indices (printed offsets) and register count
// ****************************************************************
`define BCR_IDX_CONV3_CONTROL  8'h08
`define BCR_IDX_CONV3_CONFIG   8'h09
`define BCR_IDX_CONV4_CONTROL  8'h0a
`define BCR_IDX_CONV4_CONFIG   8'h0b
`define BCR_IDX_CONV1_TARGET_A 8'h0e
`define BCR_IDX_CONV1_TARGET_B 8'h0f
`define BCR_IDX_STATUS         8'h20
`define BCR_IDX_COUNT          6

// ****************************************************************
// control register fields
// ****************************************************************
`define BCR_CTL_RESIDUAL_BIT   7
`define BCR_CTL_DISCHARGE_BIT  5
`define BCR_CTL_MONITOR_BIT    4
`define BCR_CTL_TARGET_SEL_BIT 3
`define BCR_CTL_FORCED_PWM_BIT 1
`define BCR_CTL_ENABLE_BIT     0

// ****************************************************************
// configuration register fields
// ****************************************************************
`define BCR_CFG_LIMIT_MSB      5
`define BCR_CFG_LIMIT_LSB      3
`define BCR_CFG_RAMP_MSB       2
`define BCR_CFG_RAMP_LSB       0

// ****************************************************************
// factory defaults, used when the nonvolatile image is not valid
// ****************************************************************
`define BCR_RST_CONTROL        8'h22
`define BCR_RST_CONFIG         8'h22
`define BCR_RST_TARGET         8'h00

// ****************************************************************
// current limit codes
// ****************************************************************
`define BCR_LIMIT_2A5          3'h2
`define BCR_LIMIT_3A5          3'h3
`define BCR_LIMIT_4A5          3'h4
`define BCR_LIMIT_5A5          3'h5

// ****************************************************************
// bus answers
// ****************************************************************
`define BCR_RESP_OKAY          2'h0
`define BCR_RESP_SLVERR        2'h2

`endif

// ===== hdl/bcr_pkg.sv
// types shared by the converter config bank
package bcr_pkg;

    typedef enum logic [1:0]
    {
        BCR_WR_IDLE = 2'b01,
        BCR_WR_RESP = 2'b10
    } bcr_wr_state_type;

    typedef logic [7:0] bcr_byte_type;

endpackage

// ===== hdl/bcr_defaults_mem.sv
// nonvolatile default image: six bytes captured once after reset release
`timescale 1ns/1ps
`include "bcr_consts.svh"

module bcr_defaults_mem
#(
    parameter int DEPTH = `BCR_IDX_COUNT
)
(
    input  wire logic                   aclk,        // system clock
    input  wire logic                   aresetn,     // sync reset, low active
    input  wire logic                   nvm_valid,   // image lines are good
    input  wire logic [DEPTH*8-1:0]     nvm_image,   // packed default bytes
    input  wire logic [2:0]             rd_index,    // entry to read
    output bcr_pkg::bcr_byte_type       rd_data,     // registered read data
    output logic                        loaded       // image captured
);

    bcr_pkg::bcr_byte_type mem [DEPTH];

    // ************************************************************
    // capture once: the image is sampled on the first valid cycle
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            loaded <= 1'b0;
        end
        else if (nvm_valid)
        begin
            loaded <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (aresetn && nvm_valid && !loaded)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= nvm_image[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= mem[rd_index];
        end
    end

endmodule // bcr_defaults_mem

// ===== hdl/bcr_limit_decode.sv
// decodes a peak-limit code into a supported flag for one converter
`timescale 1ns/1ps
`include "bcr_consts.svh"

module bcr_limit_decode
#(
    parameter bit ALLOW_5A5 = 1'b1
)
(
    input  wire logic [2:0] code,      // peak limit field
    output logic            supported  // code maps to a real limit
);

    always_comb
    begin
        unique case (code)
            `BCR_LIMIT_2A5,
            `BCR_LIMIT_3A5,
            `BCR_LIMIT_4A5: supported = 1'b1;
            `BCR_LIMIT_5A5: supported = ALLOW_5A5;
            default:        supported = 1'b0;
        endcase
    end

endmodule // bcr_limit_decode

// ===== hdl/bcr_regs.sv
// AXI4-Lite register bank for converter control, configuration and targets
//
// Notes on behaviour
// [RULE1] control bit 7 enables residual-voltage checking, reset zero
// [RULE2] control bit 5 enables discharge pull-down while converter is off, reset one
// [RULE3] control bit 4 enables all four monitor comparators, reset zero
// [RULE4] control bit 3 picks target register a (0) or b (1)
// [RULE5] control bit 1 forced pwm; resets one; only forced pwm honoured
// [RULE6] control bit 0 enables the converter, reset zero
// [RULE7] converter three limit bits 5:3, codes 2..5 valid, reset code 4
// [RULE8] converter four limit bits 5:3, codes 2..4 valid, reset code 4
// [RULE9] limit writes apply immediately, converter may stay enabled
// [RULE10] config bits 2:0 set ramp rate both ways, reset code 2
// [RULE11] reset values come from the nonvolatile default image
// [RULE12] each target register holds an 8-bit read/write code
// [RULE13] config three at 0x9, converter four at 0xa and 0xb, reset 0x22
// [RULE14] converter one targets at 0xe and 0xf, reset 0x00
// [RULE15] reserved bits are plain storage resetting to zero, no effect
`timescale 1ns/1ps
`include "bcr_consts.svh"

module bcr_regs
(
    input  wire logic        aclk,                  // system clock, 10 MHz
    input  wire logic        aresetn,               // sync reset, low active
    input  wire logic [7:0]  s_axi_awaddr,          // write address
    input  wire logic        s_axi_awvalid,         // write address valid
    output logic             s_axi_awready,         // write address ready
    input  wire logic [31:0] s_axi_wdata,           // write data
    input  wire logic [3:0]  s_axi_wstrb,           // write strobes
    input  wire logic        s_axi_wvalid,          // write data valid
    output logic             s_axi_wready,          // write data ready
    output logic [1:0]       s_axi_bresp,           // write response
    output logic             s_axi_bvalid,          // write response valid
    input  wire logic        s_axi_bready,          // write response ready
    input  wire logic [7:0]  s_axi_araddr,          // read address
    input  wire logic        s_axi_arvalid,         // read address valid
    output logic             s_axi_arready,         // read address ready
    output logic [31:0]      s_axi_rdata,           // read data
    output logic [1:0]       s_axi_rresp,           // read response
    output logic             s_axi_rvalid,          // read data valid
    input  wire logic        s_axi_rready,          // read data ready
    input  wire logic        nvm_valid,             // default image is valid
    input  wire logic [47:0] nvm_image,             // default bytes, index 0 low
    output logic             conv3_enable,          // converter three on
    output logic             conv3_forced_pwm,      // converter three forced pwm
    output logic             conv3_target_select,   // converter three uses target b
    output logic             conv3_monitor_en,      // converter three comparators on
    output logic             conv3_discharge_en,    // converter three pull-down on
    output logic             conv3_residual_check_en, // converter three residual check
    output logic [2:0]       conv3_peak_limit,      // converter three limit code
    output logic [2:0]       conv3_ramp_rate,       // converter three ramp code
    output logic             conv4_enable,          // converter four on
    output logic             conv4_forced_pwm,      // converter four forced pwm
    output logic             conv4_target_select,   // converter four uses target b
    output logic             conv4_monitor_en,      // converter four comparators on
    output logic             conv4_discharge_en,    // converter four pull-down on
    output logic             conv4_residual_check_en, // converter four residual check
    output logic [2:0]       conv4_peak_limit,      // converter four limit code
    output logic [2:0]       conv4_ramp_rate,       // converter four ramp code
    output logic [7:0]       conv1_target_code_a,   // converter one target a
    output logic [7:0]       conv1_target_code_b,   // converter one target b
    output logic             defaults_loaded        // default image applied
);

    // ************************************************************
    // storage
    // ************************************************************
    bcr_pkg::bcr_byte_type conv3_control;
    bcr_pkg::bcr_byte_type conv3_config;
    bcr_pkg::bcr_byte_type conv4_control;
    bcr_pkg::bcr_byte_type conv4_config;
    bcr_pkg::bcr_byte_type conv1_target_a;
    bcr_pkg::bcr_byte_type conv1_target_b;

    bcr_pkg::bcr_wr_state_type wr_state;
    logic                      aw_held;
    logic [7:0]                aw_addr;
    logic                      w_held;
    logic [7:0]                w_data;
    logic                      w_lane0;
    logic                      wr_fire;
    logic                      wr_hit;
    logic [7:0]                rd_word;
    logic                      rd_hit;
    logic                      conv3_limit_ok;
    logic                      conv4_limit_ok;

    // default image loader
    logic [2:0]                load_index;
    logic                      load_busy;
    logic                      load_wr;
    logic [2:0]                load_slot;
    bcr_pkg::bcr_byte_type     load_data;
    logic                      image_seen;

    function automatic logic [7:0] word_index(input logic [7:0] addr);
        word_index = {2'b00, addr[7:2]};
    endfunction

    function automatic bcr_pkg::bcr_byte_type merge_ctl(input bcr_pkg::bcr_byte_type v);
        // only forced pwm is supported, so the mode bit is kept set
        merge_ctl = v | (8'h01 << `BCR_CTL_FORCED_PWM_BIT); // RULE5
    endfunction

    bcr_defaults_mem #(.DEPTH(`BCR_IDX_COUNT)) u_defaults
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .nvm_valid (nvm_valid),
        .nvm_image (nvm_image),
        .rd_index  (load_index),
        .rd_data   (load_data),
        .loaded    (image_seen)
    );

    bcr_limit_decode #(.ALLOW_5A5(1'b1)) u_limit3
    (
        .code      (conv3_config[`BCR_CFG_LIMIT_MSB:`BCR_CFG_LIMIT_LSB]),
        .supported (conv3_limit_ok)
    );

    bcr_limit_decode #(.ALLOW_5A5(1'b0)) u_limit4
    (
        .code      (conv4_config[`BCR_CFG_LIMIT_MSB:`BCR_CFG_LIMIT_LSB]),
        .supported (conv4_limit_ok)
    );

    // ************************************************************
    // default image walk: one byte per cycle after the image lands
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            load_index      <= 3'h0;
            load_busy       <= 1'b0;
            load_wr         <= 1'b0;
            load_slot       <= 3'h0;
            defaults_loaded <= 1'b0;
        end
        else
        begin
            load_wr   <= load_busy;
            load_slot <= load_index;
            defaults_loaded <= defaults_loaded | (load_wr && !load_busy); // last slot lands
            if (image_seen && !defaults_loaded && !load_busy && !load_wr)
            begin
                load_busy  <= 1'b1;
                load_index <= 3'h0;
            end
            else if (load_busy)
            begin
                if (load_index == 3'(`BCR_IDX_COUNT - 1))
                    load_busy <= 1'b0;
                else
                    load_index <= load_index + 3'h1;
            end
        end
    end

    // ************************************************************
    // write channel: address and data taken in either order
    // ************************************************************
    assign s_axi_awready = (wr_state == bcr_pkg::BCR_WR_IDLE) && !aw_held;
    assign s_axi_wready  = (wr_state == bcr_pkg::BCR_WR_IDLE) && !w_held;
    assign wr_fire       = (wr_state == bcr_pkg::BCR_WR_IDLE) && aw_held && w_held;

    always_comb
    begin
        unique case (word_index(aw_addr))
            `BCR_IDX_CONV3_CONTROL, `BCR_IDX_CONV3_CONFIG,
            `BCR_IDX_CONV4_CONTROL, `BCR_IDX_CONV4_CONFIG,
            `BCR_IDX_CONV1_TARGET_A, `BCR_IDX_CONV1_TARGET_B: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state     <= bcr_pkg::BCR_WR_IDLE;
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `BCR_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            unique case (wr_state)
                bcr_pkg::BCR_WR_IDLE:
                begin
                    if (wr_fire)
                    begin
                        aw_held      <= 1'b0;
                        w_held       <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_hit ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR;
                        wr_state     <= bcr_pkg::BCR_WR_RESP;
                    end
                end
                bcr_pkg::BCR_WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        wr_state     <= bcr_pkg::BCR_WR_IDLE;
                    end
                end
                default: wr_state <= bcr_pkg::BCR_WR_IDLE;
            endcase
        end
    end

    // ************************************************************
    // register storage: bus writes, default image, reset constants
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            conv3_control  <= `BCR_RST_CONTROL;  // RULE2 RULE5
            conv3_config   <= `BCR_RST_CONFIG;   // RULE7 RULE10 RULE13
            conv4_control  <= `BCR_RST_CONTROL;  // RULE13
            conv4_config   <= `BCR_RST_CONFIG;   // RULE8 RULE13
            conv1_target_a <= `BCR_RST_TARGET;   // RULE14
            conv1_target_b <= `BCR_RST_TARGET;   // RULE14
        end
        else if (load_wr)
            unique case (load_slot)                      // RULE11
                3'h0: conv3_control  <= merge_ctl(load_data);
                3'h1: conv3_config   <= load_data;
                3'h2: conv4_control  <= merge_ctl(load_data);
                3'h3: conv4_config   <= load_data;
                3'h4: conv1_target_a <= load_data;
                3'h5: conv1_target_b <= load_data;
                default: ;
            endcase
        else if (wr_fire && w_lane0)
        begin
            // limit fields update with no enable interlock
            unique case (word_index(aw_addr))            // RULE9 RULE15
                `BCR_IDX_CONV3_CONTROL:  conv3_control  <= merge_ctl(w_data);
                `BCR_IDX_CONV3_CONFIG:   conv3_config   <= w_data;   // RULE13
                `BCR_IDX_CONV4_CONTROL:  conv4_control  <= merge_ctl(w_data);
                `BCR_IDX_CONV4_CONFIG:   conv4_config   <= w_data;
                `BCR_IDX_CONV1_TARGET_A: conv1_target_a <= w_data;   // RULE12 RULE14
                `BCR_IDX_CONV1_TARGET_B: conv1_target_b <= w_data;   // RULE12 RULE14
                default: ;
            endcase
        end
    end

    // ************************************************************
    // read channel: one cycle to rvalid
    // ************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 8'h00;
        unique case (word_index(s_axi_araddr))
            `BCR_IDX_CONV3_CONTROL:  rd_word = conv3_control;
            `BCR_IDX_CONV3_CONFIG:   rd_word = conv3_config;
            `BCR_IDX_CONV4_CONTROL:  rd_word = conv4_control;
            `BCR_IDX_CONV4_CONFIG:   rd_word = conv4_config;
            `BCR_IDX_CONV1_TARGET_A: rd_word = conv1_target_a;
            `BCR_IDX_CONV1_TARGET_B: rd_word = conv1_target_b;
            `BCR_IDX_STATUS:
                rd_word = {5'h00, conv4_limit_ok, conv3_limit_ok, defaults_loaded};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `BCR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_word};
            s_axi_rresp  <= rd_hit ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ************************************************************
    // converter-facing fields, straight from the registers except discharge, which is gated off by enable
    // ************************************************************
    assign conv3_residual_check_en = conv3_control[`BCR_CTL_RESIDUAL_BIT];   // RULE1
    assign conv3_discharge_en      = conv3_control[`BCR_CTL_DISCHARGE_BIT]
                                     && !conv3_control[`BCR_CTL_ENABLE_BIT]; // RULE2
    assign conv3_monitor_en        = conv3_control[`BCR_CTL_MONITOR_BIT];    // RULE3
    assign conv3_target_select     = conv3_control[`BCR_CTL_TARGET_SEL_BIT]; // RULE4
    assign conv3_forced_pwm        = conv3_control[`BCR_CTL_FORCED_PWM_BIT]; // RULE5
    assign conv3_enable            = conv3_control[`BCR_CTL_ENABLE_BIT];     // RULE6
    assign conv3_peak_limit        = conv3_config[`BCR_CFG_LIMIT_MSB:`BCR_CFG_LIMIT_LSB]; // RULE7
    assign conv3_ramp_rate         = conv3_config[`BCR_CFG_RAMP_MSB:`BCR_CFG_RAMP_LSB];   // RULE10
    assign conv4_residual_check_en = conv4_control[`BCR_CTL_RESIDUAL_BIT];   // RULE1
    assign conv4_discharge_en      = conv4_control[`BCR_CTL_DISCHARGE_BIT]
                                     && !conv4_control[`BCR_CTL_ENABLE_BIT]; // RULE2
    assign conv4_monitor_en        = conv4_control[`BCR_CTL_MONITOR_BIT];    // RULE3
    assign conv4_target_select     = conv4_control[`BCR_CTL_TARGET_SEL_BIT]; // RULE4
    assign conv4_forced_pwm        = conv4_control[`BCR_CTL_FORCED_PWM_BIT]; // RULE5
    assign conv4_enable            = conv4_control[`BCR_CTL_ENABLE_BIT];     // RULE6
    assign conv4_peak_limit        = conv4_config[`BCR_CFG_LIMIT_MSB:`BCR_CFG_LIMIT_LSB]; // RULE8
    assign conv4_ramp_rate         = conv4_config[`BCR_CFG_RAMP_MSB:`BCR_CFG_RAMP_LSB];   // RULE10
    assign conv1_target_code_a     = conv1_target_a; // RULE12
    assign conv1_target_code_b     = conv1_target_b; // RULE12

endmodule // bcr_regs

// ===== testbench/bcr_regs_props.sv
// concurrent checks on the converter config bank ports
`timescale 1ns/1ps
module bcr_regs_props
(
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic        s_axi_arready, s_axi_rvalid, conv3_enable, conv4_enable,
    input wire logic        conv3_discharge_en, conv4_discharge_en, conv3_forced_pwm,
    input wire logic        conv4_forced_pwm,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [2:0]  conv3_peak_limit, conv4_peak_limit, conv3_ramp_rate,
    input wire logic [7:0]  conv1_target_code_a
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_DISCHARGE: assert property (
        !(conv3_enable && conv3_discharge_en) && !(conv4_enable && conv4_discharge_en))
        else $error("pull-down active on a running converter");
    AST_FORCED_PWM: assert property (
        conv3_forced_pwm && conv4_forced_pwm) else $error("forced pwm left");
    AST_RESET_CONFIG: assert property ($rose(aresetn) |->
        conv3_peak_limit == 3'h4 && conv4_peak_limit == 3'h4 && conv3_ramp_rate == 3'h2)
        else $error("config fields not at reset codes");
    AST_RESET_CONTROL: assert property ($rose(aresetn) |->
        !conv3_enable && !conv4_enable && conv3_discharge_en && conv1_target_code_a == 8'h00)
        else $error("control or target not at reset value");
    AST_WRITE_RESP: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late or early");
    AST_BRESP_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_READ_RESP: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    AST_READ_WIDTH: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    AST_BUSY_BLOCK: assert property (
        (s_axi_rvalid |-> !s_axi_arready) and (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready))
        else $error("request taken while answer pending");
    cover property (conv3_enable && conv3_peak_limit == 3'h5);
    cover property (s_axi_bvalid && !s_axi_bready);
    cover property (conv3_discharge_en ##1 conv3_enable);
endmodule // bcr_regs_props

bind bcr_regs bcr_regs_props u_props (.*);

// ===== testbench/bcr_regs_tb.sv
// self-checking bench for the converter config bank
`timescale 1ns/1ps
`include "bcr_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module bcr_regs_tb;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, nvm_valid, defaults_loaded, conv3_enable, conv4_enable;
    logic        conv3_forced_pwm, conv3_target_select, conv3_monitor_en, conv3_discharge_en;
    logic        conv4_forced_pwm, conv4_target_select, conv4_monitor_en, conv4_discharge_en;
    logic        conv3_residual_check_en, conv4_residual_check_en;
    logic [2:0]  conv3_peak_limit, conv3_ramp_rate, conv4_peak_limit, conv4_ramp_rate;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, conv1_target_code_a, conv1_target_code_b, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_wdata, s_axi_rdata, t, q;
    logic [3:0]  s_axi_wstrb;
    logic [47:0] nvm_image;
    logic [7:0]  m [6];
    logic [7:0]  idx [6] = '{`BCR_IDX_CONV3_CONTROL, `BCR_IDX_CONV3_CONFIG,
        `BCR_IDX_CONV4_CONTROL, `BCR_IDX_CONV4_CONFIG, `BCR_IDX_CONV1_TARGET_A, `BCR_IDX_CONV1_TARGET_B};
    logic [31:0] seed = 32'h00013fc3; // 81859
    int          failures = 0, cmp_count = 0, i;

    bcr_regs DUT (.*);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // forced pwm cannot be cleared, so control reads always carry bit 1
    function automatic logic [7:0] fx(input int k, input logic [7:0] v);
        return (k == 0 || k == 2) ? (v | 8'h02) : v;
    endfunction

    // ****************************************************************
    // bus tasks: bready/rready start at random to stall the answer
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
        logic [31:0] s;
        s = rnd();
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= s[0];
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= 1'b1;
        end
        rs = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic [31:0] s;
        s = rnd();
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= s[0];
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= 1'b1;
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic chk_all();
        for (int k = 0; k < 6; k++)
        begin
            rd(idx[k] << 2, q, r);
            `CHK({r, q}, {`BCR_RESP_OKAY, 24'h0, m[k]})
        end
        rd(8'h80, q, r);
        `CHK(q[2:0], {m[3][5:3] inside {[2:4]}, m[1][5:3] inside {[2:5]}, nvm_valid})
        `CHK({conv3_residual_check_en, conv4_residual_check_en}, {m[0][7], m[2][7]})
        `CHK({conv3_discharge_en, conv4_discharge_en}, {m[0][5] & ~m[0][0], m[2][5] & ~m[2][0]})
        `CHK({conv3_monitor_en, conv4_monitor_en}, {m[0][4], m[2][4]})
        `CHK({conv3_target_select, conv4_target_select}, {m[0][3], m[2][3]})
        `CHK({conv3_enable, conv4_enable}, {m[0][0], m[2][0]})
        `CHK(conv3_peak_limit, m[1][5:3])
        `CHK(conv4_peak_limit, m[3][5:3])
        `CHK({conv3_ramp_rate, conv4_ramp_rate}, {m[1][2:0], m[3][2:0]})
        `CHK({conv1_target_code_a, conv1_target_code_b}, {m[4], m[5]})
    endtask
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial
    begin
        #500000 failures++;
        report_and_stop();
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, nvm_valid, nvm_image} = 97'h0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        m = '{8'h22, 8'h22, 8'h22, 8'h22, 8'h00, 8'h00};
        chk_all();
        for (int n = 0; n < 50; n++)
        begin
            t = rnd();
            i = (n < 2) ? 2 * n : (n < 18) ? ((n < 10) ? 1 : 3) : int'(t % 32'h6);
            d = (n < 2) ? 8'h01 : (n < 18) ? {n[1:0], n[2:0], n[2:0]} : t[15:8];
            wr(idx[i] << 2, d, r);
            `CHK(r, `BCR_RESP_OKAY)
            m[i] = fx(i, d);
            if (n % 8 == 7) chk_all();
        end
        wr(8'h00, 8'h5a, r);
        rd(8'h04, q, d[1:0]);
        `CHK({r, d[1:0], q}, {`BCR_RESP_SLVERR, `BCR_RESP_SLVERR, 32'h0})
        chk_all();
        nvm_image <= 48'({rnd(), rnd()});
        nvm_valid <= 1'b1;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int w = 0; w < 60 && defaults_loaded !== 1'b1; w++) @(posedge aclk);
        `CHK(defaults_loaded, 1'b1)
        for (int k = 0; k < 6; k++) m[k] = fx(k, nvm_image[k * 8 +: 8]);
        chk_all();
        report_and_stop();
    end
endmodule // bcr_regs_tb
